/* design/sclh_regs.vh */
// Character codes, limits and timing constants of the serial link handler.
`ifndef SCLH_REGS_VH
`define SCLH_REGS_VH
`define SCLH_STX      8'h02
`define SCLH_ETX      8'h03
`define SCLH_EOT      8'h04
`define SCLH_ACK      8'h06
`define SCLH_LF       8'h0a
`define SCLH_CR       8'h0d
`define SCLH_NAK      8'h15
`define SCLH_SPACE    8'h20
`define SCLH_STAR     8'h2a
`define SCLH_COLON    8'h3a
`define SCLH_SEMI     8'h3b
`define SCLH_QMARK    8'h3f
`define SCLH_CH_A     8'h41
`define SCLH_CH_E     8'h45
`define SCLH_CH_I     8'h49
`define SCLH_CH_O     8'h4f
`define SCLH_CH_U     8'h55
`define SCLH_LOW_A    8'h61
`define SCLH_LOW_Z    8'h7a
`define SCLH_CASE_BIT 8'h20
`define SCLH_HDR_MAX  4'hc
`define SCLH_SHORT4   4'h4
`define SCLH_SHORT3   4'h3
`define SCLH_ADDR_DEF 5'h09
`define SCLH_ADDR_MIN 5'h01
`define SCLH_CLK_HZ   32'h0098_9680
`define SCLH_TMO_S    32'h0000_000f
`define SCLH_MS_PER_S 32'h0000_03e8
`endif

/* design/sclh_timer.v */
// Prescaled protocol timeout timer with restart and stop.
`timescale 1ns/100ps
`default_nettype none
module sclh_timer #(
  parameter integer TICK_CYCLES = 10000,
  parameter integer TMO_TICKS   = 15000
) (
  input  wire ref_clk,
  input  wire srst,
  input  wire clr,
  input  wire run,
  output wire expired
);
  localparam integer PRE_END_I = TICK_CYCLES - 1;
  localparam [23:0]  PRE_END   = PRE_END_I[23:0];
  localparam [23:0]  TICK_END  = TMO_TICKS[23:0];
  reg [23:0] pre_q;
  reg [23:0] ticks_q;
  reg        exp_q;

  // The prescaler divides the system clock into millisecond ticks.
  always @(posedge ref_clk) begin
    if (srst || clr) begin
      pre_q   <= 24'h00_0000;
      ticks_q <= 24'h00_0000;
      exp_q   <= 1'b0;
    end else if (run && !exp_q) begin
      if (pre_q == PRE_END) begin
        pre_q   <= 24'h00_0000;
        ticks_q <= ticks_q + 24'h00_0001;
        if (ticks_q + 24'h00_0001 == TICK_END) begin
          exp_q <= 1'b1;
        end
      end else begin
        pre_q <= pre_q + 24'h00_0001;
      end
    end
  end

  assign expired = exp_q;
endmodule // sclh_timer
`default_nettype wire

/* design/sclh_kw_match.v */
// Case-blind long/short form matcher for one command header keyword.
`timescale 1ns/100ps
`default_nettype none
`include "sclh_regs.vh"
module sclh_kw_match #(
  parameter [95:0] KW     = 96'h0,
  parameter [3:0]  KW_LEN = 4'h4
) (
  input  wire       ref_clk,
  input  wire       srst,
  input  wire       clr,
  input  wire       chr_en,
  input  wire [7:0] chr,
  output wire       hit
);
  localparam integer C4_POS = (KW_LEN >= `SCLH_SHORT4) ?
                              KW_LEN - `SCLH_SHORT4 : 0;
  localparam [7:0]   C4     = KW[8*C4_POS +: 8];
  localparam         V4     = (C4 == `SCLH_CH_A) || (C4 == `SCLH_CH_E) ||
                              (C4 == `SCLH_CH_I) || (C4 == `SCLH_CH_O) ||
                              (C4 == `SCLH_CH_U);
  localparam [3:0]   SLEN   = (KW_LEN > `SCLH_SHORT4 && V4) ? `SCLH_SHORT3 :
                              (KW_LEN < `SCLH_SHORT4) ? KW_LEN :
                              `SCLH_SHORT4;

  reg [3:0] pos_q;
  reg       ok_q;

  function [7:0] upcase;
    input [7:0] c;
    begin
      if (c >= `SCLH_LOW_A && c <= `SCLH_LOW_Z) begin
        upcase = c & ~`SCLH_CASE_BIT;
      end else begin
        upcase = c;
      end
    end
  endfunction

  always @(posedge ref_clk) begin
    if (srst || clr) begin
      pos_q <= 4'h0;
      ok_q  <= 1'b1;
    end else if (chr_en) begin
      if (pos_q >= KW_LEN) begin
        ok_q <= 1'b0;
      end else if (upcase(chr) != KW[8*(KW_LEN-1-pos_q) +: 8]) begin
        ok_q <= 1'b0;
      end
      if (pos_q != 4'hf) begin
        pos_q <= pos_q + 4'h1;
      end
    end
  end

  // Only the exact long form or the exact short form is a hit.
  assign hit = ok_q && (pos_q == KW_LEN || pos_q == SLEN);
endmodule // sclh_kw_match
`default_nettype wire

/* design/sclh_link.v */
// Serial command link handler with framing, timers and remote state.
`timescale 1ns/100ps
`default_nettype none
`include "sclh_regs.vh"
// Notes on behaviour
// - Idle device accepts frame STX, command text, LF, ETX in order.
// - After a complete frame reply ACK if valid, else NAK.
// - Response block is STX, data text, CR, LF, ETX.
// - Blocks repeat until data run out, then EOT and idle.
// - Response timer starts when a block's ETX is fully sent.
// - Response timer stops on a valid ACK from the host.
// - Response timer reaching 15 s sends EOT and returns idle.
// - Receive timer starts on the frame's opening STX.
// - Each arriving frame character restarts the receive timer.
// - Receive timer stops on the closing ETX.
// - Receive timeout discards the partial command and returns idle.
// - Bus address selectable 1 to 31, default 9, effective at once.
// - Addressed command enters remote; all keys but local key disabled.
// - Local key or go-to-local leaves remote state.
// - Local lockout disables local key; only go-to-local releases.
// - Each command header level holds at most 12 characters.
// - Headers match only their exact long or short form.
// - Short form is four letters, three if fourth is vowel.
// - Header matching ignores letter case.
// - Colon separates levels; optional levels may be left out.
// - Link follows the character-oriented control procedure.
module sclh_link #(
  parameter integer TICK_CYCLES = `SCLH_CLK_HZ / `SCLH_MS_PER_S,
  parameter integer TMO_TICKS   = `SCLH_TMO_S * `SCLH_MS_PER_S,
  parameter integer NKW         = 10
) (
  input  wire       ref_clk,
  input  wire       srst,
  input  wire       rx_valid,
  input  wire [7:0] rx_data,
  output wire       tx_valid,
  output wire [7:0] tx_data,
  input  wire       tx_ready,
  output wire       cmd_chr_valid,
  output wire [7:0] cmd_chr,
  output wire       cmd_valid,
  output wire       cmd_query,
  output wire       cmd_abort,
  input  wire       resp_valid,
  input  wire [7:0] resp_data,
  input  wire       resp_last,
  input  wire       resp_final,
  output wire       resp_ready,
  input  wire       addr_set,
  input  wire [4:0] addr_in,
  output wire [4:0] bus_addr,
  input  wire       bus_msg,
  input  wire [4:0] bus_msg_addr,
  input  wire       gtl_cmd,
  input  wire       llo_cmd,
  input  wire       local_softkey,
  output wire       remote,
  output wire       lockout,
  output wire       front_keys_en,
  output wire       local_key_en
);
  localparam [3:0] ST_IDLE  = 4'h0;
  localparam [3:0] ST_RX    = 4'h1;
  localparam [3:0] ST_WEOT  = 4'h2;
  localparam [3:0] ST_TSTX  = 4'h3;
  localparam [3:0] ST_TDATA = 4'h4;
  localparam [3:0] ST_TCR   = 4'h5;
  localparam [3:0] ST_TLF   = 4'h6;
  localparam [3:0] ST_TETX  = 4'h7;
  localparam [3:0] ST_TEND  = 4'h8;
  localparam [3:0] ST_WACK  = 4'h9;
  localparam [3:0] ST_TEOT  = 4'ha;
  localparam [3:0] ST_FIN   = 4'hb;

  reg [3:0] state_q;
  reg [7:0] tx_data_q;
  reg       tx_valid_q;
  reg       go_eot_q;
  reg       more_q;
  reg       cmd_valid_q;
  reg       cmd_query_q;
  reg       cmd_abort_q;
  reg       chr_valid_q;
  reg [7:0] chr_q;
  reg [3:0] lvl_len_q;
  reg       in_hdr_q;
  reg       first_q;
  reg       ok_q;
  reg       any_q;
  reg       lf_q;
  reg       query_q;
  reg [4:0] addr_q;
  reg       remote_q;
  reg       lockout_q;

  wire           tx_free = !tx_valid_q || tx_ready;
  wire           sent    = tx_valid_q && tx_ready;
  wire           tmo_a;
  wire           tmo_b;
  wire [NKW-1:0] hits;
  wire           rx_chr  = (state_q == ST_RX) && rx_valid && !tmo_b;
  wire           is_sep  = (rx_data == `SCLH_COLON) ||
                           (rx_data == `SCLH_SPACE) ||
                           (rx_data == `SCLH_QMARK) ||
                           (rx_data == `SCLH_SEMI)  ||
                           (rx_data == `SCLH_LF);
  wire           skip    = (rx_data == `SCLH_STAR) && (lvl_len_q == 4'h0);
  wire           lvl_end = rx_chr && in_hdr_q && is_sep;
  wire           feed    = rx_chr && in_hdr_q && !is_sep && !skip &&
                           (rx_data != `SCLH_ETX);
  wire           frm_ok  = ok_q && any_q && lf_q;

  // Keyword set known to the parser, stored right-aligned.
  function [95:0] kw_of;
    input integer idx;
    begin
      case (idx)
        0:       kw_of = "DISPLAY";
        1:       kw_of = "CONTRAST";
        2:       kw_of = "SOURCE";
        3:       kw_of = "VOLTAGE";
        4:       kw_of = "CURRENT";
        5:       kw_of = "SYSTEM";
        6:       kw_of = "INITIATE";
        7:       kw_of = "IMMEDIATE";
        8:       kw_of = "CLS";
        default: kw_of = "RST";
      endcase
    end
  endfunction

  function [3:0] kw_len;
    input integer idx;
    begin
      case (idx)
        0, 3, 4: kw_len = 4'h7;
        1, 6:    kw_len = 4'h8;
        2, 5:    kw_len = 4'h6;
        7:       kw_len = 4'h9;
        default: kw_len = 4'h3;
      endcase
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NKW; gi = gi + 1) begin : g_kw
      sclh_kw_match #(
        .KW     (kw_of(gi)),
        .KW_LEN (kw_len(gi))
      ) u_kw (
        .ref_clk (ref_clk),
        .srst    (srst),
        .clr     (lvl_end || state_q == ST_IDLE),
        .chr_en  (feed),
        .chr     (rx_data),
        .hit     (hits[gi])
      );
    end
  endgenerate

  sclh_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .TMO_TICKS   (TMO_TICKS)
  ) u_tmr_resp (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clr     (state_q != ST_WACK),
    .run     (state_q == ST_WACK),
    .expired (tmo_a)
  );

  sclh_timer #(
    .TICK_CYCLES (TICK_CYCLES),
    .TMO_TICKS   (TMO_TICKS)
  ) u_tmr_recv (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clr     (state_q == ST_IDLE || rx_chr),
    .run     (state_q == ST_RX),
    .expired (tmo_b)
  );

  // Header parser; a level closes on a separator and must name a keyword.
  always @(posedge ref_clk) begin
    if (srst || state_q == ST_IDLE) begin
      lvl_len_q <= 4'h0;
      in_hdr_q  <= 1'b1;
      first_q   <= 1'b1;
      ok_q      <= 1'b1;
      any_q     <= 1'b0;
      lf_q      <= 1'b0;
      query_q   <= 1'b0;
    end else if (rx_chr && rx_data != `SCLH_ETX) begin
      lf_q <= (rx_data == `SCLH_LF);
      if (feed && lvl_len_q != 4'hf) begin
        lvl_len_q <= lvl_len_q + 4'h1;
      end
      if (lvl_end) begin
        lvl_len_q <= 4'h0;
        first_q   <= 1'b0;
        if (rx_data != `SCLH_COLON) begin
          in_hdr_q <= 1'b0;
        end
        if (rx_data == `SCLH_QMARK) begin
          query_q <= 1'b1;
        end
        if (lvl_len_q == 4'h0) begin
          if (!(first_q && rx_data == `SCLH_COLON)) begin
            ok_q <= 1'b0;
          end
        end else begin
          any_q <= 1'b1;
          if (lvl_len_q > `SCLH_HDR_MAX || hits == {NKW{1'b0}}) begin
            ok_q <= 1'b0;
          end
        end
      end
    end
  end

  // Link sequencer for frames, replies and response blocks.
  always @(posedge ref_clk) begin
    if (srst) begin
      state_q     <= ST_IDLE;
      tx_data_q   <= 8'h00;
      tx_valid_q  <= 1'b0;
      go_eot_q    <= 1'b0;
      more_q      <= 1'b0;
      cmd_valid_q <= 1'b0;
      cmd_query_q <= 1'b0;
      cmd_abort_q <= 1'b0;
      chr_valid_q <= 1'b0;
      chr_q       <= 8'h00;
    end else begin
      cmd_valid_q <= 1'b0;
      cmd_abort_q <= 1'b0;
      chr_valid_q <= 1'b0;
      if (sent) begin
        tx_valid_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          if (rx_valid && rx_data == `SCLH_STX) begin
            state_q <= ST_RX;
          end
        end
        ST_RX: begin
          if (tmo_b) begin
            state_q     <= ST_IDLE;
            cmd_abort_q <= 1'b1;
          end else if (rx_valid && rx_data == `SCLH_ETX) begin
            tx_data_q   <= frm_ok ? `SCLH_ACK : `SCLH_NAK;
            tx_valid_q  <= 1'b1;
            go_eot_q    <= frm_ok && query_q;
            cmd_valid_q <= frm_ok;
            cmd_query_q <= query_q;
            cmd_abort_q <= !frm_ok;
            state_q     <= ST_FIN;
          end else if (rx_valid) begin
            chr_valid_q <= 1'b1;
            chr_q       <= rx_data;
          end
        end
        ST_WEOT: begin
          if (rx_valid && rx_data == `SCLH_EOT) begin
            state_q <= ST_TSTX;
          end
        end
        ST_TSTX: begin
          if (tx_free) begin
            tx_data_q  <= `SCLH_STX;
            tx_valid_q <= 1'b1;
            state_q    <= ST_TDATA;
          end
        end
        ST_TDATA: begin
          if (tx_free && resp_valid) begin
            tx_data_q  <= resp_data;
            tx_valid_q <= 1'b1;
            if (resp_last) begin
              more_q  <= !resp_final;
              state_q <= ST_TCR;
            end
          end
        end
        ST_TCR: begin
          if (tx_free) begin
            tx_data_q  <= `SCLH_CR;
            tx_valid_q <= 1'b1;
            state_q    <= ST_TLF;
          end
        end
        ST_TLF: begin
          if (tx_free) begin
            tx_data_q  <= `SCLH_LF;
            tx_valid_q <= 1'b1;
            state_q    <= ST_TETX;
          end
        end
        ST_TETX: begin
          if (tx_free) begin
            tx_data_q  <= `SCLH_ETX;
            tx_valid_q <= 1'b1;
            state_q    <= ST_TEND;
          end
        end
        ST_TEND: begin
          if (sent) begin
            state_q <= ST_WACK;
          end
        end
        ST_WACK: begin
          if (tmo_a) begin
            state_q <= ST_TEOT;
          end else if (rx_valid && rx_data == `SCLH_ACK) begin
            state_q <= more_q ? ST_TSTX : ST_TEOT;
          end
        end
        ST_TEOT: begin
          if (tx_free) begin
            tx_data_q  <= `SCLH_EOT;
            tx_valid_q <= 1'b1;
            go_eot_q   <= 1'b0;
            state_q    <= ST_FIN;
          end
        end
        ST_FIN: begin
          if (sent) begin
            state_q <= go_eot_q ? ST_WEOT : ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Bus address and remote, local and lockout state.
  always @(posedge ref_clk) begin
    if (srst) begin
      addr_q    <= `SCLH_ADDR_DEF;
      remote_q  <= 1'b0;
      lockout_q <= 1'b0;
    end else begin
      if (addr_set && addr_in >= `SCLH_ADDR_MIN) begin
        addr_q <= addr_in;
      end
      if ((bus_msg && bus_msg_addr == addr_q) || cmd_valid_q) begin
        remote_q <= 1'b1;
      end else if (gtl_cmd || (local_softkey && !lockout_q)) begin
        remote_q <= 1'b0;
      end
      if (llo_cmd) begin
        lockout_q <= 1'b1;
      end else if (gtl_cmd) begin
        lockout_q <= 1'b0;
      end
    end
  end

  assign tx_valid      = tx_valid_q;
  assign tx_data       = tx_data_q;
  assign resp_ready    = (state_q == ST_TDATA) && tx_free;
  assign cmd_chr_valid = chr_valid_q;
  assign cmd_chr       = chr_q;
  assign cmd_valid     = cmd_valid_q;
  assign cmd_query     = cmd_query_q;
  assign cmd_abort     = cmd_abort_q;
  assign bus_addr      = addr_q;
  assign remote        = remote_q;
  assign lockout       = lockout_q;
  assign front_keys_en = !remote_q;
  assign local_key_en  = remote_q && !lockout_q;
endmodule // sclh_link
`default_nettype wire

/* sim/sclh_link_sva.sv */
// Concurrent checks on the ports of the serial command link handler.
`timescale 1ns/100ps
`default_nettype none
module sclh_link_sva #(
  parameter integer TICK_CYCLES = 10000,
  parameter integer TMO_TICKS   = 15000
) (
  input wire       ref_clk,
  input wire       srst,
  input wire       rx_valid,
  input wire [7:0] rx_data,
  input wire       tx_valid,
  input wire [7:0] tx_data,
  input wire       tx_ready,
  input wire       cmd_valid,
  input wire       cmd_abort,
  input wire       cmd_query,
  input wire       addr_set,
  input wire [4:0] addr_in,
  input wire [4:0] bus_addr,
  input wire       bus_msg,
  input wire [4:0] bus_msg_addr,
  input wire       gtl_cmd,
  input wire       llo_cmd,
  input wire       local_softkey,
  input wire       remote,
  input wire       lockout,
  input wire       front_keys_en,
  input wire       local_key_en
);
  localparam int TMO_CY = TICK_CYCLES * TMO_TICKS;
  logic wait_q;
  int   cnt_q;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // Counts cycles from a sent block end until the host sends ACK or an EOT is loaded for transmit.
  always @(posedge ref_clk) begin
    if (srst || (rx_valid && rx_data == 8'h06) ||
        (tx_valid && tx_data == 8'h04)) begin
      wait_q <= 1'b0;
      cnt_q  <= 0;
    end else if (tx_valid && tx_ready && tx_data == 8'h03) begin
      wait_q <= 1'b1;
      cnt_q  <= 0;
    end else if (wait_q) begin
      cnt_q  <= cnt_q + 1;
    end
  end
  chk_front_keys:
    assert property (front_keys_en == !remote)
    else $error("front keys enable does not follow remote state");
  chk_local_key:
    assert property (local_key_en == (remote && !lockout))
    else $error("local key enable wrong");
  chk_ack_load:
    assert property (cmd_valid |-> tx_valid && tx_data == 8'h06)
    else $error("accepted frame without acknowledge");
  chk_nak_load:
    assert property (cmd_abort && $past(rx_valid) |->
                     tx_valid && tx_data == 8'h15)
    else $error("refused frame without not-acknowledge");
  chk_tx_hold:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("transmit character dropped before taken");
  chk_remote_set:
    assert property (cmd_valid || (bus_msg && bus_msg_addr == bus_addr)
                     |=> remote)
    else $error("addressed command did not enter remote");
  chk_gtl_clear:
    assert property (gtl_cmd && !llo_cmd && !bus_msg && !cmd_valid
                     |=> !remote && !lockout)
    else $error("go-to-local did not return to local");
  chk_softkey_local:
    assert property (remote && !lockout && local_softkey && !bus_msg &&
                     !cmd_valid && !llo_cmd |=> !remote)
    else $error("local key did not leave remote");
  chk_llo_set:
    assert property (llo_cmd |=> lockout)
    else $error("lockout not set");
  chk_lockout_keeps:
    assert property (lockout && !gtl_cmd |=> remote || !$past(remote))
    else $error("remote left while locked out");
  chk_addr_load:
    assert property (addr_set && addr_in != 5'h00 |=> bus_addr == $past(addr_in))
    else $error("bus address not loaded");
  chk_addr_keep:
    assert property (!(addr_set && addr_in != 5'h00) |=> $stable(bus_addr))
    else $error("bus address changed without a load");
  chk_rsp_limit:
    assert property (cnt_q <= TMO_CY + TICK_CYCLES + 4)
    else $error("response timeout overdue");
  chk_rsp_early:
    assert property (wait_q && tx_valid && tx_data == 8'h04 |->
                     cnt_q >= TMO_CY - TICK_CYCLES)
    else $error("end of transmission before response timeout");
  cover property (cmd_valid && cmd_query);
  cover property (cmd_abort && !$past(rx_valid));
  cover property (lockout && local_softkey);
  cover property (wait_q && tx_valid && tx_data == 8'h04);
endmodule // sclh_link_sva
bind sclh_link sclh_link_sva #(.TICK_CYCLES(TICK_CYCLES),
  .TMO_TICKS(TMO_TICKS)) sclh_link_sva_i (.ref_clk(ref_clk), .srst(srst),
  .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_ready(tx_ready), .cmd_valid(cmd_valid),
  .cmd_abort(cmd_abort), .cmd_query(cmd_query), .addr_set(addr_set),
  .addr_in(addr_in), .bus_addr(bus_addr), .bus_msg(bus_msg),
  .bus_msg_addr(bus_msg_addr), .gtl_cmd(gtl_cmd), .llo_cmd(llo_cmd),
  .local_softkey(local_softkey), .remote(remote), .lockout(lockout),
  .front_keys_en(front_keys_en), .local_key_en(local_key_en));
`default_nettype wire

/* sim/sclh_host.sv */
// Host computer model on the serial link of the command link handler.
`timescale 1ns/100ps
`default_nettype none
module sclh_host (
  input  wire        ref_clk,
  input  wire        slow,
  input  wire        tx_valid,
  input  wire  [7:0] tx_data,
  output logic       rx_valid,
  output logic [7:0] rx_data,
  output logic       tx_ready
);
  logic [7:0] got [$];
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'hff;
    tx_ready = 1'b0;
  end
  // Takes a character on an edge with both sides high; slow stalls.
  always @(posedge ref_clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  task automatic put(input logic [7:0] c);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_data  <= c;
  endtask
  // An idle line shows the inverse of the last character.
  task automatic rest();
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask
  task automatic frame(input string s);
    put(8'h02);
    foreach (s[i]) put(s[i]);
    put(8'h0a);
    put(8'h03);
    rest();
  endtask
endmodule // sclh_host
`default_nettype wire

/* sim/sclh_link_bench.sv */
// Self-checking bench for the serial command link handler.
`timescale 1ns/100ps
`default_nettype none
module sclh_link_bench;
  logic       ref_clk = 1'b0;
  logic       srst = 1'b1;
  logic       slow = 1'b0;
  logic       rx_valid, tx_valid, tx_ready, cmd_chr_valid, cmd_valid;
  logic       cmd_query, cmd_abort, resp_ready, remote, lockout;
  logic       front_keys_en, local_key_en;
  logic [7:0] rx_data, tx_data, cmd_chr;
  logic       resp_valid = 1'b0, resp_last = 1'b0, resp_final = 1'b0;
  logic [7:0] resp_data = 8'h00;
  logic       addr_set = 1'b0, bus_msg = 1'b0, gtl_cmd = 1'b0;
  logic       llo_cmd = 1'b0, local_softkey = 1'b0;
  logic [4:0] addr_in = 5'h00, bus_msg_addr = 5'h00, bus_addr;
  logic [7:0] rb [4] = '{8'h35, 8'h30, 8'h31, 8'h32};
  logic [3:0] rl = 4'he;
  logic [7:0] lc = 8'h00;
  int         rn = 0, ri = 0, n_ok = 0, n_ab = 0, wt = 0;
  int         n_mismatch = 0, n_checks = 0;
  always #50 ref_clk = ~ref_clk;
  sclh_link #(.TICK_CYCLES(4), .TMO_TICKS(10)) sclh_link_i (
    .ref_clk(ref_clk), .srst(srst), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .cmd_chr_valid(cmd_chr_valid), .cmd_chr(cmd_chr), .cmd_valid(cmd_valid),
    .cmd_query(cmd_query), .cmd_abort(cmd_abort), .resp_valid(resp_valid),
    .resp_data(resp_data), .resp_last(resp_last), .resp_final(resp_final),
    .resp_ready(resp_ready), .addr_set(addr_set), .addr_in(addr_in),
    .bus_addr(bus_addr), .bus_msg(bus_msg), .bus_msg_addr(bus_msg_addr),
    .gtl_cmd(gtl_cmd), .llo_cmd(llo_cmd), .local_softkey(local_softkey),
    .remote(remote), .lockout(lockout), .front_keys_en(front_keys_en),
    .local_key_en(local_key_en));
  sclh_host sclh_host_i (.ref_clk(ref_clk), .slow(slow), .tx_valid(tx_valid),
    .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_ready(tx_ready));
  // Response source: bytes up to rn, block ends marked in rl.
  wire [31:0] nx = ri + (resp_valid && resp_ready);
  always @(posedge ref_clk) begin
    ri         <= nx;
    resp_valid <= (nx < rn);
    resp_data  <= rb[nx[1:0]];
    resp_last  <= rl[nx[1:0]];
    resp_final <= (nx == rn - 1);
  end
  always @(posedge ref_clk) begin
    if (cmd_valid === 1'b1) n_ok++;
    if (cmd_abort === 1'b1) n_ab++;
    if (cmd_chr_valid === 1'b1) lc <= cmd_chr;
  end
  task automatic chk8(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic expect_tx(input logic [7:0] exp);
    wt = 0;
    while (sclh_host_i.got.size() == 0 && wt < 400) begin
      @(negedge ref_clk);
      wt++;
    end
    chk8("tx char", exp,
         sclh_host_i.got.size() ? sclh_host_i.got.pop_front() : 8'hxx);
  endtask
  task automatic pulse(input logic [4:0] m, input logic [4:0] a);
    @(posedge ref_clk);
    addr_set      <= m[4];
    bus_msg       <= m[3];
    gtl_cmd       <= m[2];
    llo_cmd       <= m[1];
    local_softkey <= m[0];
    addr_in       <= a;
    bus_msg_addr  <= a;
    @(posedge ref_clk);
    addr_set      <= 1'b0;
    bus_msg       <= 1'b0;
    gtl_cmd       <= 1'b0;
    llo_cmd       <= 1'b0;
    local_softkey <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic t_headers();
    string cmd [8];
    cmd = '{":disp:contrast 5", "INIT", "init:imm", "*RST",
            "SOURCE:VOLTAGE 1", "INIT:IMME", "DISPL", "DISPLAYDISPLA"};
    foreach (cmd[i]) begin
      sclh_host_i.frame(cmd[i]);
      expect_tx(i < 5 ? 8'h06 : 8'h15);
    end
    @(negedge ref_clk);
    chk8("last text char", 8'h0a, lc);
    chk8("accepted", 8'h05, n_ok[7:0]);
    chk8("refused", 8'h03, n_ab[7:0]);
    chk8("remote keys", 8'h02, {6'h0, remote, front_keys_en});
  endtask
  task automatic t_query();
    logic [7:0] e [12];
    e = '{8'h02, 8'h35, 8'h30, 8'h0d, 8'h0a, 8'h03,
          8'h02, 8'h31, 8'h0d, 8'h0a, 8'h03, 8'h04};
    slow = 1'b1;
    sclh_host_i.frame("DISP:CONT?");
    expect_tx(8'h06);
    chk8("query flag", 8'h01, {7'h0, cmd_query});
    rn = 3;
    sclh_host_i.put(8'h02);
    sclh_host_i.put(8'h04);
    sclh_host_i.rest();
    foreach (e[i]) begin
      expect_tx(e[i]);
      if (i == 5 || i == 10) begin
        sclh_host_i.put(8'h06);
        sclh_host_i.rest();
      end
    end
    slow = 1'b0;
  endtask
  task automatic t_rsp_timeout();
    logic [7:0] e [5];
    e = '{8'h02, 8'h32, 8'h0d, 8'h0a, 8'h03};
    sclh_host_i.frame("DISP:CONT?");
    expect_tx(8'h06);
    rn = 4;
    sclh_host_i.put(8'h04);
    sclh_host_i.rest();
    foreach (e[i]) expect_tx(e[i]);
    expect_tx(8'h04);
    chk8("response wait", 8'h01, {7'h0, wt >= 36 && wt <= 48});
    sclh_host_i.frame("INIT");
    expect_tx(8'h06);
  endtask
  task automatic t_rx_timeout();
    int ab;
    sclh_host_i.put(8'h02);
    sclh_host_i.put("I");
    sclh_host_i.rest();
    repeat (30) @(posedge ref_clk);
    sclh_host_i.put("N");
    sclh_host_i.rest();
    repeat (30) @(posedge ref_clk);
    sclh_host_i.put("I");
    sclh_host_i.put("T");
    sclh_host_i.put(8'h0a);
    sclh_host_i.put(8'h03);
    sclh_host_i.rest();
    expect_tx(8'h06);
    ab = n_ab;
    sclh_host_i.put(8'h02);
    sclh_host_i.put("D");
    sclh_host_i.rest();
    repeat (60) @(posedge ref_clk);
    @(negedge ref_clk);
    chk8("discard abort", 8'h01, 8'(n_ab - ab));
    chk8("text char", 8'h44, lc);
    chk8("silent discard", 8'h00, 8'(sclh_host_i.got.size()));
    sclh_host_i.frame("CURR");
    expect_tx(8'h06);
  endtask
  task automatic t_remote();
    logic [11:0] st [9];
    st = '{{5'h01, 5'h09, 2'b00}, {5'h08, 5'h09, 2'b10},
           {5'h02, 5'h09, 2'b11}, {5'h01, 5'h09, 2'b11},
           {5'h04, 5'h09, 2'b00}, {5'h10, 5'h1f, 2'b00},
           {5'h10, 5'h00, 2'b00}, {5'h08, 5'h09, 2'b00},
           {5'h08, 5'h1f, 2'b10}};
    foreach (st[i]) begin
      pulse(st[i][11:7], st[i][6:2]);
      chk8("remote state", {4'h0, st[i][1:0], !st[i][1], st[i][1:0] == 2'b10},
           {4'h0, remote, lockout, front_keys_en, local_key_en});
    end
    chk8("bus address", 8'h1f, {3'h0, bus_addr});
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(negedge ref_clk);
    chk8("reset state", 8'h49, {bus_addr, remote, lockout, front_keys_en});
    chk8("reset idle", 8'h00, {6'h0, local_key_en, tx_valid});
    t_headers();
    t_query();
    t_rsp_timeout();
    t_rx_timeout();
    t_remote();
    report_and_stop();
  end
endmodule // sclh_link_bench
`default_nettype wire
